// File: dasp_pkg.sv
package dasp_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int PC_W = 23;
  localparam int PC_HI_W = 7;
  localparam int LIT_W = 10;
  localparam logic [WORD_W-1:0] STACK_PTR_RESET = 16'h0800;
  localparam logic [WORD_W-1:0] FRAME_PTR_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] STACK_FLOOR = 16'h0800;
  localparam logic [WORD_W-1:0] STACK_STEP = 16'h0002;
  localparam logic [WORD_W-1:0] WORD_BYTES = 16'h0002;
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_BOTH = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_STORE, OP_MOVE, OP_PUSH, OP_POP, OP_CALL, OP_EXC,
    OP_FRAME_LINK, OP_FRAME_UNLINK, OP_SET_STACK, OP_SET_FRAME, OP_LIT
  } dasp_op_e;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} dasp_size_e;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADD_CARRY, ALU_AND, ALU_INCL_OR, ALU_RET_LIT, ALU_SUB,
    ALU_SUB_BORROW, ALU_EXCL_OR
  } dasp_alu_e;

  typedef struct packed {
    dasp_op_e op;
    dasp_size_e size;
    dasp_alu_e alu;
    logic [WORD_W-1:0] src;
    logic [WORD_W-1:0] dst;
    logic [2*WORD_W-1:0] data;
    logic [PC_W-1:0] program_counter;
    logic [BYTE_W-1:0] status_low_byte;
    logic priority_level_bit3;
    logic [LIT_W-1:0] lit;
  } dasp_cmd_s;

  typedef struct packed {
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic [1:0] be;
    logic rd;
    logic wr;
  } dasp_mem_s;
endpackage : dasp_pkg

// File: dasp_lit.sv
`timescale 1ns/1ps
module dasp_lit (
  input wire logic [dasp_pkg::LIT_W-1:0] lit_in,
  input wire logic byte_mode_in,
  input wire dasp_pkg::dasp_alu_e alu_in,
  output logic [dasp_pkg::WORD_W-1:0] value_out,
  output logic ok_out
);
  import dasp_pkg::*;

  // Byte mode keeps the low byte and extends its top bit
  always_comb begin
    if (byte_mode_in) begin
      value_out = {{(WORD_W-BYTE_W){lit_in[BYTE_W-1]}}, lit_in[BYTE_W-1:0]};
    end else begin
      value_out = {{(WORD_W-LIT_W){1'b0}}, lit_in};
    end
  end

  always_comb begin
    case (alu_in)
      ALU_ADD, ALU_ADD_CARRY, ALU_AND, ALU_INCL_OR, ALU_RET_LIT, ALU_SUB, ALU_SUB_BORROW,
      ALU_EXCL_OR: begin
        ok_out = 1'b1;
      end
      default: begin
        ok_out = 1'b0;
      end
    endcase
  end
endmodule : dasp_lit

// File: dasp_unit.sv
`timescale 1ns/1ps
module dasp_unit (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire dasp_pkg::dasp_cmd_s cmd_in,
  input wire logic [dasp_pkg::WORD_W-1:0] mem_rdata_in,
  output logic cmd_ready_out,
  output dasp_pkg::dasp_mem_s mem_out,
  output logic [2*dasp_pkg::WORD_W-1:0] rd_data_out,
  output logic done_out,
  output logic addr_err_out,
  output logic stack_err_out,
  output logic [dasp_pkg::WORD_W-1:0] stack_ptr_out,
  output logic [dasp_pkg::WORD_W-1:0] frame_ptr_out,
  output logic [dasp_pkg::WORD_W-1:0] lit_out,
  output logic lit_ok_out
);
  import dasp_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RD, S_CAP, S_WR, S_DONE} dasp_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic odd_word(input dasp_size_e sz, input logic [WORD_W-1:0] a);
    odd_word = (sz != SZ_BYTE) && a[0];
  endfunction : odd_word

  function automatic logic [WORD_W-1:0] even(input logic [WORD_W-1:0] a);
    even = {a[WORD_W-1:1], 1'b0};
  endfunction : even

  function automatic logic [1:0] lanes(input dasp_size_e sz, input logic [WORD_W-1:0] a);
    if (sz != SZ_BYTE) begin
      lanes = BE_BOTH;
    end else if (a[0]) begin
      lanes = BE_HI;
    end else begin
      lanes = BE_LO;
    end
  endfunction : lanes

  function automatic dasp_mem_s rd_req(input dasp_size_e sz, input logic [WORD_W-1:0] a);
    rd_req = '0;
    rd_req.addr = even(a);
    rd_req.be = lanes(sz, a);
    rd_req.rd = 1'b1;
  endfunction : rd_req

  function automatic dasp_mem_s wr_req(input dasp_size_e sz, input logic [WORD_W-1:0] a,
                                       input logic [WORD_W-1:0] d, input logic en);
    wr_req = '0;
    wr_req.addr = even(a);
    wr_req.be = lanes(sz, a);
    wr_req.wdata = (sz == SZ_BYTE) ? {d[BYTE_W-1:0], d[BYTE_W-1:0]} : d;
    wr_req.wr = en;
  endfunction : wr_req

  function automatic logic [WORD_W-1:0] pick(input dasp_size_e sz, input logic [WORD_W-1:0] a,
                                             input logic [WORD_W-1:0] d);
    if (sz != SZ_BYTE) begin
      pick = d;
    end else if (a[0]) begin
      pick = {{(WORD_W-BYTE_W){1'b0}}, d[WORD_W-1:BYTE_W]};
    end else begin
      pick = {{(WORD_W-BYTE_W){1'b0}}, d[BYTE_W-1:0]};
    end
  endfunction : pick

  function automatic logic [WORD_W-1:0] push_lo(input dasp_cmd_s c,
                                                input logic [WORD_W-1:0] fp);
    case (c.op)
      OP_PUSH: begin
        push_lo = c.data[WORD_W-1:0];
      end
      OP_FRAME_LINK: begin
        push_lo = fp;
      end
      default: begin
        push_lo = c.program_counter[WORD_W-1:0];
      end
    endcase
  endfunction : push_lo

  function automatic logic [WORD_W-1:0] push_hi(input dasp_cmd_s c);
    if (c.op == OP_EXC) begin
      push_hi = {c.status_low_byte, c.priority_level_bit3, c.program_counter[PC_W-1:WORD_W]};
    end else begin
      push_hi = {{(WORD_W-PC_HI_W){1'b0}}, c.program_counter[PC_W-1:WORD_W]};
    end
  endfunction : push_hi

  ////////////////////////////////////////////////////////////////////////////////
  // State

  dasp_state_e state;
  dasp_state_e next_state;
  dasp_cmd_s cur;
  dasp_mem_s next_mem;
  logic hi;
  logic next_hi;
  logic mis;
  logic accept;
  logic dword;
  logic push2;
  logic [WORD_W-1:0] stack_ptr_reg;
  logic [WORD_W-1:0] frame_ptr_reg;
  logic [WORD_W-1:0] lit_val;
  logic lit_ok;
  logic [WORD_W-1:0] lit_bytes;
  logic [WORD_W-1:0] rd_lo;

  assign accept = (state == S_IDLE) && cmd_valid_in;
  assign dword = cur.size == SZ_DWORD;
  assign push2 = (cur.op == OP_CALL) || (cur.op == OP_EXC);
  assign lit_bytes = {{(WORD_W-LIT_W){1'b0}}, cmd_in.lit};
  assign stack_ptr_out = stack_ptr_reg;
  assign frame_ptr_out = frame_ptr_reg;
  assign rd_lo = ((cur.op == OP_LOAD) || (cur.op == OP_MOVE)) ?
                 pick(cur.size, cur.src, mem_rdata_in) : mem_rdata_in;

  dasp_lit u_lit (
    .lit_in(cmd_in.lit),
    .byte_mode_in(cmd_in.size == SZ_BYTE),
    .alu_in(cmd_in.alu),
    .value_out(lit_val),
    .ok_out(lit_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_state = state;
    next_hi = hi;
    next_mem = '0;
    case (state)
      S_IDLE: begin
        next_hi = 1'b0;
        if (cmd_valid_in) begin
          case (cmd_in.op)
            OP_LOAD, OP_MOVE: begin
              next_state = S_RD;
              next_mem = rd_req(cmd_in.size, cmd_in.src);
            end
            OP_STORE: begin
              next_state = S_WR;
              next_mem = wr_req(cmd_in.size, cmd_in.dst, cmd_in.data[WORD_W-1:0],
                                !odd_word(cmd_in.size, cmd_in.dst));
            end
            OP_PUSH, OP_CALL, OP_EXC, OP_FRAME_LINK: begin
              next_state = S_WR;
              next_mem = wr_req(SZ_WORD, stack_ptr_reg, push_lo(cmd_in, frame_ptr_reg),
                                1'b1);
            end
            OP_POP: begin
              next_state = S_RD;
              next_mem = rd_req(SZ_WORD, stack_ptr_reg - STACK_STEP);
            end
            OP_FRAME_UNLINK: begin
              next_state = S_RD;
              next_mem = rd_req(SZ_WORD, even(frame_ptr_reg) - STACK_STEP);
            end
            default: begin
              next_state = S_DONE;
            end
          endcase
        end
      end
      S_RD: begin
        next_state = S_CAP;
      end
      S_CAP: begin
        if (dword && !hi) begin
          next_state = S_RD;
          next_hi = 1'b1;
          next_mem = rd_req(SZ_WORD, cur.src + WORD_BYTES);
        end else if (cur.op == OP_MOVE) begin
          next_state = S_WR;
          next_mem = wr_req(cur.size, cur.dst, rd_lo, !odd_word(cur.size, cur.dst));
        end else begin
          next_state = S_DONE;
        end
      end
      S_WR: begin
        if (dword && !hi) begin
          next_state = S_WR;
          next_hi = 1'b1;
          next_mem = wr_req(SZ_WORD, cur.dst + WORD_BYTES, cur.data[2*WORD_W-1:WORD_W],
                            !mis);
        end else if (push2 && !hi) begin
          next_state = S_WR;
          next_hi = 1'b1;
          next_mem = wr_req(SZ_WORD, stack_ptr_reg, push_hi(cur), 1'b1);
        end else begin
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= S_IDLE;
      hi <= 1'b0;
      mem_out <= '0;
      cmd_ready_out <= 1'b1;
    end else begin
      state <= next_state;
      hi <= next_hi;
      mem_out <= next_mem;
      cmd_ready_out <= next_state == S_IDLE;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
      mis <= 1'b0;
    end else if (accept) begin
      cur <= cmd_in;
      mis <= (odd_word(cmd_in.size, cmd_in.src) && (cmd_in.op inside {OP_LOAD, OP_MOVE})) ||
             (odd_word(cmd_in.size, cmd_in.dst) &&
              (cmd_in.op inside {OP_STORE, OP_MOVE}));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion, read data and literal

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_out <= 1'b0;
      addr_err_out <= 1'b0;
    end else begin
      done_out <= state == S_DONE;
      addr_err_out <= (state == S_DONE) && mis;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else if (accept) begin
      rd_data_out <= '0;
    end else if (state == S_CAP) begin
      if (hi) begin
        rd_data_out[2*WORD_W-1:WORD_W] <= mem_rdata_in;
      end else begin
        rd_data_out[WORD_W-1:0] <= rd_lo;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lit_out <= '0;
      lit_ok_out <= 1'b0;
    end else if (accept && (cmd_in.op == OP_LIT)) begin
      lit_out <= lit_val;
      lit_ok_out <= lit_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stack and frame pointers

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stack_ptr_reg <= STACK_PTR_RESET;
    end else if (accept) begin
      case (cmd_in.op)
        OP_PUSH, OP_CALL, OP_EXC: begin
          stack_ptr_reg <= stack_ptr_reg + STACK_STEP;
        end
        OP_POP: begin
          stack_ptr_reg <= stack_ptr_reg - STACK_STEP;
        end
        OP_FRAME_LINK: begin
          stack_ptr_reg <= even(stack_ptr_reg + STACK_STEP + lit_bytes);
        end
        OP_FRAME_UNLINK: begin
          stack_ptr_reg <= even(frame_ptr_reg) - STACK_STEP;
        end
        OP_SET_STACK: begin
          stack_ptr_reg <= even(cmd_in.data[WORD_W-1:0]);
        end
        default: begin
        end
      endcase
    end else if ((state == S_WR) && push2 && !hi) begin
      stack_ptr_reg <= stack_ptr_reg + STACK_STEP;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_ptr_reg <= FRAME_PTR_RESET;
    end else if (accept && (cmd_in.op == OP_FRAME_LINK)) begin
      frame_ptr_reg <= stack_ptr_reg + STACK_STEP;
    end else if (accept && (cmd_in.op == OP_SET_FRAME)) begin
      frame_ptr_reg <= cmd_in.data[WORD_W-1:0];
    end else if ((state == S_CAP) && (cur.op == OP_FRAME_UNLINK)) begin
      frame_ptr_reg <= mem_rdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stack_err_out <= 1'b0;
    end else begin
      stack_err_out <= stack_ptr_reg < STACK_FLOOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_call_take;
    accept && (cmd_in.op == OP_CALL);
  endsequence

  sequence s_call_lo;
    mem_out.wr && (mem_out.wdata == cur.program_counter[WORD_W-1:0]);
  endsequence

  sequence s_call_hi;
    mem_out.wr && (mem_out.wdata ==
      {{(WORD_W-PC_HI_W){1'b0}}, cur.program_counter[PC_W-1:WORD_W]});
  endsequence

  a_word_odd_err: assert property (
    accept && (cmd_in.op == OP_LOAD) && (cmd_in.size == SZ_WORD) && cmd_in.src[0]
    |-> ##4 addr_err_out && done_out)
    else $error("odd word read did not raise address error");

  a_dword_err: assert property (
    accept && (cmd_in.op == OP_STORE) && (cmd_in.size == SZ_DWORD) && cmd_in.dst[0]
    |-> ##4 addr_err_out)
    else $error("odd double word did not raise address error");

  a_err_at_end: assert property (
    addr_err_out |-> done_out && (state == S_IDLE))
    else $error("address error raised before instruction end");

  a_read_forced: assert property (
    accept && (cmd_in.op == OP_LOAD) && (cmd_in.size == SZ_WORD)
    |=> mem_out.rd && (mem_out.addr == {$past(cmd_in.src[WORD_W-1:1]), 1'b0}))
    else $error("word read address not forced even");

  a_write_blocked: assert property (
    accept && (cmd_in.op == OP_STORE) && (cmd_in.size == SZ_WORD) && cmd_in.dst[0]
    |=> !mem_out.wr [*3])
    else $error("misaligned word write reached memory");

  a_byte_lane: assert property (
    accept && (cmd_in.op == OP_STORE) && (cmd_in.size == SZ_BYTE)
    |=> mem_out.be == ($past(cmd_in.dst[0]) ? BE_HI : BE_LO))
    else $error("byte written to wrong lane");

  a_reset_vals: assert property (
    $rose(rst_n_in) |-> (stack_ptr_reg == STACK_PTR_RESET) && (frame_ptr_reg == FRAME_PTR_RESET))
    else $error("pointers wrong after reset");

  a_push_step: assert property (
    accept && (cmd_in.op == OP_PUSH)
    |=> (stack_ptr_reg == $past(stack_ptr_reg) + STACK_STEP) &&
        (mem_out.addr == $past(stack_ptr_reg)) && mem_out.wr)
    else $error("push did not write then step by one word");

  a_pop_step: assert property (
    accept && (cmd_in.op == OP_POP)
    |=> (stack_ptr_reg == $past(stack_ptr_reg) - STACK_STEP) &&
        mem_out.rd && (mem_out.addr == stack_ptr_reg))
    else $error("pop did not step then read");

  a_call_words: assert property (
    s_call_take |=> s_call_lo ##1 s_call_hi)
    else $error("call pushed wrong counter words");

  a_exc_word: assert property (
    accept && (cmd_in.op == OP_EXC) |-> ##2 mem_out.wr && (mem_out.wdata ==
      {cur.status_low_byte, cur.priority_level_bit3, cur.program_counter[PC_W-1:WORD_W]}))
    else $error("exception upper word malformed");

  a_sp_even: assert property (
    !stack_ptr_reg[0])
    else $error("stack pointer became odd");

  a_link: assert property (
    accept && (cmd_in.op == OP_FRAME_LINK)
    |=> (frame_ptr_reg == $past(stack_ptr_reg) + STACK_STEP) &&
        (mem_out.wdata == $past(frame_ptr_reg)))
    else $error("link did not save and move frame");

  a_unlink: assert property (
    accept && (cmd_in.op == OP_FRAME_UNLINK)
    |=> mem_out.rd ##2 (frame_ptr_reg == $past(mem_rdata_in)))
    else $error("unlink did not restore frame");

  a_stack_floor: assert property (
    (stack_ptr_reg < STACK_FLOOR) |=> stack_err_out)
    else $error("stack error missing below floor");

  a_lit_byte: assert property (
    accept && (cmd_in.op == OP_LIT) && (cmd_in.size == SZ_BYTE)
    |=> (lit_out[BYTE_W-1:0] == $past(cmd_in.lit[BYTE_W-1:0])) &&
        (lit_out[WORD_W-1:BYTE_W] == {BYTE_W{lit_out[BYTE_W-1]}}) && lit_ok_out)
    else $error("byte literal not sign extended");
endmodule : dasp_unit

// File: dasp_mem_model.sv
`timescale 1ns/1ps
module dasp_mem_model (
  input wire logic core_clk_in,
  input wire dasp_pkg::dasp_mem_s mem_in,
  output logic [dasp_pkg::WORD_W-1:0] rdata_out
);
  import dasp_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Byte array, addresses wrap at 8 KB
  logic [BYTE_W-1:0] mem [0:8191];
  logic [12:0] a;
  assign a = {mem_in.addr[12:1], 1'b0};
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
    rdata_out = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sync RAM: data the cycle after rd; idle bus toggles every cycle
  always @(posedge core_clk_in) begin
    if (mem_in.wr) begin
      if (mem_in.be[0]) mem[a] <= mem_in.wdata[7:0];
      if (mem_in.be[1]) mem[a+13'h1] <= mem_in.wdata[15:8];
    end
    if (mem_in.rd) rdata_out <= {mem[a+13'h1], mem[a]};
    else rdata_out <= ~rdata_out;
  end
endmodule : dasp_mem_model

// File: tb_data_align_and_stack_pointer_unit.sv
`timescale 1ns/1ps
module tb_data_align_and_stack_pointer_unit;
  import dasp_pkg::*;
  logic core_clk_in, rst_n_in, cmd_valid_in, cmd_ready_out, done_out;
  logic addr_err_out, stack_err_out, lit_ok_out, err_seen;
  dasp_cmd_s cmd_in;
  dasp_mem_s mem_out;
  logic [WORD_W-1:0] mem_rdata_in, stack_ptr_out, frame_ptr_out, lit_out;
  logic [31:0] rd_data_out, res;
  int errors, tests_run;
  dasp_unit uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .mem_rdata_in(mem_rdata_in), .cmd_ready_out(cmd_ready_out),
    .mem_out(mem_out), .rd_data_out(rd_data_out), .done_out(done_out),
    .addr_err_out(addr_err_out), .stack_err_out(stack_err_out), .stack_ptr_out(stack_ptr_out),
    .frame_ptr_out(frame_ptr_out), .lit_out(lit_out), .lit_ok_out(lit_ok_out));
  dasp_mem_model mem_i (.core_clk_in(core_clk_in), .mem_in(mem_out), .rdata_out(mem_rdata_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  task finish_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function logic [15:0] peek(input int a);
    return {mem_i.mem[a+1], mem_i.mem[a]};
  endfunction : peek
  function dasp_cmd_s mk(dasp_op_e op, dasp_size_e sz, logic [15:0] s, logic [15:0] d,
                         logic [31:0] v);
    mk = '0;
    mk.op = op;
    mk.size = sz;
    mk.src = s;
    mk.dst = d;
    mk.data = v;
  endfunction : mk
  // One command: take, then wait for done; error flag must not show early
  task issue(input dasp_cmd_s c);
    int n;
    logic early;
    n = 0;
    early = 1'b0;
    @(negedge core_clk_in);
    cmd_in = c;
    cmd_valid_in = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_in = 1'b0;
    while (done_out !== 1'b1 && n < 20) begin
      early = early | (addr_err_out === 1'b1);
      @(negedge core_clk_in);
      n++;
    end
    chk(n < 20, 1'b1);
    chk(early, 1'b0);
    chk(cmd_ready_out, 1'b1);
    res = rd_data_out;
    err_seen = addr_err_out;
  endtask : issue
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(stack_ptr_out, 16'h0800);
    chk(frame_ptr_out, 16'h0000);
    chk(stack_err_out, 1'b0);
  endtask : t_reset
  task t_stack;
    issue(mk(OP_PUSH, SZ_WORD, 16'h0, 16'h0, 32'h3a5c));
    chk(stack_ptr_out, 16'h0802);
    issue(mk(OP_PUSH, SZ_WORD, 16'h0, 16'h0, 32'h1234));
    chk(stack_ptr_out, 16'h0804);
    chk(peek(16'h0800), 16'h3a5c);
    chk(mem_i.mem[16'h0800], 8'h5c);
    issue(mk(OP_POP, SZ_WORD, 16'h0, 16'h0, 32'h0));
    chk(res[15:0], 16'h1234);
    chk(stack_ptr_out, 16'h0802);
  endtask : t_stack
  task t_call_exc;
    dasp_cmd_s c;
    c = mk(OP_CALL, SZ_WORD, 16'h0, 16'h0, 32'h0);
    c.program_counter = 23'h5a1234;
    issue(c);
    chk(peek(16'h0802), 16'h1234);
    chk(peek(16'h0804), 16'h005a);
    chk(stack_ptr_out, 16'h0806);
    c.op = OP_EXC;
    c.program_counter = 23'h3f0abc;
    c.status_low_byte = 8'ha5;
    c.priority_level_bit3 = 1'b1;
    issue(c);
    chk(peek(16'h0806), 16'h0abc);
    chk(peek(16'h0808), 16'ha5bf);
    chk(stack_ptr_out, 16'h080a);
  endtask : t_call_exc
  task t_frame;
    dasp_cmd_s c;
    issue(mk(OP_SET_FRAME, SZ_WORD, 16'h0a00, 16'h0a00, 32'h0a00));
    chk(frame_ptr_out, 16'h0a00);
    c = mk(OP_FRAME_LINK, SZ_WORD, 16'h0, 16'h0, 32'h0);
    c.lit = 10'h004;
    issue(c);
    chk(peek(16'h080a), 16'h0a00);
    chk(frame_ptr_out, 16'h080c);
    chk(stack_ptr_out, 16'h0810);
    issue(mk(OP_FRAME_UNLINK, SZ_WORD, 16'h0, 16'h0, 32'h0));
    chk(stack_ptr_out, 16'h080a);
    chk(frame_ptr_out, 16'h0a00);
  endtask : t_frame
  task t_sp_limit;
    issue(mk(OP_SET_STACK, SZ_WORD, 16'h0901, 16'h0901, 32'h0901));
    chk(stack_ptr_out, 16'h0900);
    issue(mk(OP_SET_STACK, SZ_WORD, 16'h07fe, 16'h07fe, 32'h07fe));
    @(negedge core_clk_in);
    chk(stack_err_out, 1'b1);
    issue(mk(OP_SET_STACK, SZ_WORD, 16'h0800, 16'h0800, 32'h0800));
    @(negedge core_clk_in);
    chk(stack_err_out, 1'b0);
  endtask : t_sp_limit
  task t_align;
    mem_i.mem[16'h1000] = 8'h34;
    mem_i.mem[16'h1001] = 8'h12;
    mem_i.mem[16'h1002] = 8'h78;
    mem_i.mem[16'h1003] = 8'h56;
    mem_i.mem[16'h1004] = 8'hbc;
    mem_i.mem[16'h1005] = 8'h9a;
    issue(mk(OP_LOAD, SZ_WORD, 16'h1001, 16'h0, 32'h0));
    chk(res[15:0], 16'h1234);
    chk(err_seen, 1'b1);
    issue(mk(OP_LOAD, SZ_WORD, 16'h1002, 16'h0, 32'h0));
    chk(res[15:0], 16'h5678);
    chk(err_seen, 1'b0);
    issue(mk(OP_STORE, SZ_WORD, 16'h0, 16'h1003, 32'hbeef));
    chk(peek(16'h1002), 16'h5678);
    chk(peek(16'h1004), 16'h9abc);
    chk(err_seen, 1'b1);
    issue(mk(OP_STORE, SZ_DWORD, 16'h0, 16'h1006, 32'h89abcdef));
    chk(mem_i.mem[16'h1006], 8'hef);
    chk(peek(16'h1008), 16'h89ab);
    chk(err_seen, 1'b0);
    issue(mk(OP_LOAD, SZ_DWORD, 16'h1007, 16'h0, 32'h0));
    chk(res, 32'h89abcdef);
    chk(err_seen, 1'b1);
    issue(mk(OP_MOVE, SZ_WORD, 16'h1001, 16'h1010, 32'h0));
    chk(peek(16'h1010), 16'h1234);
    chk(err_seen, 1'b1);
    issue(mk(OP_MOVE, SZ_WORD, 16'h1000, 16'h1013, 32'h0));
    chk(peek(16'h1012), 16'h0000);
    chk(err_seen, 1'b1);
    issue(mk(OP_STORE, SZ_BYTE, 16'h0, 16'h100b, 32'h77));
    chk({mem_i.mem[16'h100b], mem_i.mem[16'h100a]}, 16'h7700);
  endtask : t_align
  task t_literal;
    dasp_cmd_s c;
    c = mk(OP_LIT, SZ_WORD, 16'h0, 16'h0, 32'h0);
    c.lit = 10'h3ff;
    for (int k = 0; k < 8; k++) begin
      c.alu = dasp_alu_e'(k);
      issue(c);
      chk(lit_ok_out, 1'b1);
      chk(lit_out, 16'h03ff);
    end
    c.size = SZ_BYTE;
    issue(c);
    chk(lit_out, 16'hffff);
    c.lit = 10'h080;
    issue(c);
    chk(lit_out, 16'hff80);
    c.lit = 10'h07f;
    issue(c);
    chk(lit_out, 16'h007f);
  endtask : t_literal
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    errors = 0;
    tests_run = 0;
    repeat (3) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    t_reset;
    t_stack;
    t_call_exc;
    t_frame;
    t_sp_limit;
    t_align;
    t_literal;
    finish_test;
  end
  initial begin
    #100000;
    errors++;
    finish_test;
  end
endmodule : tb_data_align_and_stack_pointer_unit
